// File: core/gdpc_pkg.sv
// Package of constants and types for the gated delayed-pulse counter
`default_nettype none

package gdpc_pkg;

    // =====================================================================
    // Widths and values
    // =====================================================================
    localparam int          GDPC_WIDTH    = 16;          // Counter width
    localparam logic [15:0] GDPC_ONE      = 16'h0001;    // Last count before terminal
    localparam logic [15:0] GDPC_DECR     = 16'h0001;    // Down-count step
    localparam logic [15:0] GDPC_RST_CNT  = 16'h0000;    // Counter reset value

    // =====================================================================
    // Modes and states
    // =====================================================================
    // Operating mode select
    typedef enum logic [0:0] {
        GDPC_MODE_LEVEL = 1'b0,   // Level-gated delayed pulse
        GDPC_MODE_EDGE  = 1'b1    // Edge-triggered delayed pulse
    } gdpc_mode_type;

    // Sequence states, one-hot
    typedef enum logic [3:0] {
        GDPC_ST_IDLE  = 4'b0001,  // Disarmed
        GDPC_ST_WAIT  = 4'b0010,  // Armed, waiting for gate edge
        GDPC_ST_DELAY = 4'b0100,  // Counting toward first terminal count
        GDPC_ST_PULSE = 4'b1000   // Counting toward second terminal count
    } gdpc_state_type;

endpackage : gdpc_pkg

`default_nettype wire

// File: core/gdpc_edge_det.sv
// Rising-edge detector for synchronous input strobes
`default_nettype none

module gdpc_edge_det
    import gdpc_pkg::*;
(
    input  wire logic sys_clk_in,   // System clock
    input  wire logic sys_rst_in,   // Asynchronous reset, active high
    input  wire logic level_in,     // Level to watch
    output logic      rise_out      // One-cycle pulse on rising edge
);

    // =====================================================================
    // Edge detection
    // =====================================================================
    logic level_reg;                // Previous level

    // Remember last level
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            level_reg <= 1'b0;
        else
            level_reg <= level_in;
    end

    // Rising edge is new high over old low
    assign rise_out = level_in & ~level_reg;

endmodule : gdpc_edge_det

`default_nettype wire

// File: core/gdpc_counter.sv
// Gated delayed-pulse down counter with level and edge modes
//
// Operation
// - Level mode: gate qualifies source edges
// - Level mode: no counting while disarmed
// - Armed level mode: count only while gate active
// - First terminal count reloads from hold
// - Level mode second terminal: load, disarm
// - Level mode: inactive gate stretches delay and pulse
// - Edge mode: start only after armed gate edge
// - Edge mode: ignore gate edges while disarmed
// - Edge mode: count from next source edge
// - Edge mode: disarm after second terminal count
// - Edge mode: gate ignored after trigger
// - Terminal count follows counter value one
`default_nettype none

module gdpc_counter
    import gdpc_pkg::*;
(
    input  wire logic                  sys_clk_in,     // System clock
    input  wire logic                  sys_rst_in,     // Async reset, high
    input  wire logic                  source_in,      // Count source level
    input  wire logic                  gate_in,        // Gate, active high
    input  wire logic                  arm_in,         // Arm command pulse
    input  wire logic                  disarm_in,      // Disarm command pulse
    input  wire logic                  load_cmd_in,    // Load counter command
    input  wire gdpc_mode_type         counter_mode_config_in, // Mode select
    input  wire logic [GDPC_WIDTH-1:0] load_value_in,  // Load register value
    input  wire logic [GDPC_WIDTH-1:0] hold_value_in,  // Hold register value
    output logic [GDPC_WIDTH-1:0]      count_out,      // Counter contents
    output logic                       armed_out,      // Counter armed
    output logic                       terminal_count_event_out, // Event pulse
    output logic                       pulse_out       // Delayed pulse
);

    // =====================================================================
    // Declarations
    // =====================================================================
    gdpc_state_type          state_reg;     // Sequence state
    gdpc_state_type          state_next;    // Next sequence state
    logic [GDPC_WIDTH-1:0]   count_reg;     // Counter value
    logic [GDPC_WIDTH-1:0]   count_next;    // Next counter value
    logic                    term_reg;      // Registered terminal count
    logic                    pulse_reg;     // Registered output pulse
    logic                    armed_reg;     // Registered armed flag
    logic                    src_rise;      // Source rising edge
    logic                    gate_rise;     // Gate rising edge
    logic                    count_en;      // Qualified source edge
    logic                    term_hit;      // Terminal count this edge
    logic                    counting;      // In delay or pulse phase

    // =====================================================================
    // Edge detectors
    // =====================================================================
    gdpc_edge_det u_src_edge (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .level_in   (source_in),
        .rise_out   (src_rise)
    );

    gdpc_edge_det u_gate_edge (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .level_in   (gate_in),
        .rise_out   (gate_rise)
    );

    // Terminal-count test on the value before decrement
    function automatic logic gdpc_at_one(input logic [GDPC_WIDTH-1:0] v);
        return v == GDPC_ONE;
    endfunction : gdpc_at_one

    // =====================================================================
    // Count qualification
    // =====================================================================
    assign counting = (state_reg == GDPC_ST_DELAY) ||
                      (state_reg == GDPC_ST_PULSE);

    // Qualify source edges by mode
    always_comb
    begin
        if (counter_mode_config_in == GDPC_MODE_LEVEL)
            count_en = counting && src_rise && gate_in;
        else
            count_en = counting && src_rise;
        term_hit = count_en && gdpc_at_one(count_reg);
    end

    // =====================================================================
    // Sequence control
    // =====================================================================
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            GDPC_ST_IDLE:
            begin
                // Arm starts level mode directly, edge mode waits
                if (arm_in)
                begin
                    if (counter_mode_config_in == GDPC_MODE_LEVEL)
                        state_next = GDPC_ST_DELAY;
                    else
                        state_next = GDPC_ST_WAIT;
                end
                // Gate edges ignored while disarmed
            end
            GDPC_ST_WAIT:
            begin
                if (disarm_in)
                    state_next = GDPC_ST_IDLE;
                else if (gate_rise)
                    state_next = GDPC_ST_DELAY;
            end
            GDPC_ST_DELAY:
            begin
                if (disarm_in)
                    state_next = GDPC_ST_IDLE;
                else if (term_hit)
                    state_next = GDPC_ST_PULSE;
            end
            GDPC_ST_PULSE:
            begin
                if (disarm_in || term_hit)
                    state_next = GDPC_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            state_reg <= GDPC_ST_IDLE;
        else
            state_reg <= state_next;
    end

    // =====================================================================
    // Counter datapath
    // =====================================================================
    always_comb
    begin
        count_next = count_reg;
        if (load_cmd_in && (state_reg == GDPC_ST_IDLE))
            count_next = load_value_in;
        else if (term_hit && (state_reg == GDPC_ST_DELAY))
            count_next = hold_value_in;
        else if (term_hit)
            count_next = load_value_in;
        else if (count_en)
            count_next = count_reg - GDPC_DECR;
    end

    // Counter register
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            count_reg <= GDPC_RST_CNT;
        else
            count_reg <= count_next;
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    // Terminal count pulse, delayed output pulse and armed flag
    // Armed flag registered so the output comes straight from a flop
    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            term_reg  <= 1'b0;
            pulse_reg <= 1'b0;
            armed_reg <= 1'b0;
        end
        else
        begin
            term_reg  <= term_hit;
            pulse_reg <= (state_next == GDPC_ST_PULSE);
            armed_reg <= (state_next != GDPC_ST_IDLE);
        end
    end

    assign count_out                = count_reg;
    assign armed_out                = armed_reg;
    assign terminal_count_event_out = term_reg;
    assign pulse_out                = pulse_reg;

    // =====================================================================
    // Assertions
    // =====================================================================
    hold_gate_a: assert property (
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (counter_mode_config_in == GDPC_MODE_LEVEL && counting && !gate_in
         && !load_cmd_in && !disarm_in) |=> $stable(count_reg))
        else $error("Counter moved while gate inactive");

    idle_still_a: assert property (
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (state_reg == GDPC_ST_IDLE && !load_cmd_in)
        |=> $stable(count_reg))
        else $error("Counter moved while disarmed");

    first_reload_a: assert property (
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (term_hit && state_reg == GDPC_ST_DELAY && !disarm_in)
        |=> count_reg == $past(hold_value_in)
            && state_reg == GDPC_ST_PULSE)
        else $error("First terminal count did not reload hold");

    second_reload_a: assert property (
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (term_hit && state_reg == GDPC_ST_PULSE)
        |=> count_reg == $past(load_value_in) && !armed_out)
        else $error("Second terminal count did not reload and disarm");

    wait_edge_a: assert property (
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (state_reg == GDPC_ST_WAIT && !gate_rise)
        |=> state_reg != GDPC_ST_DELAY)
        else $error("Edge mode started without gate edge");

    idle_gate_a: assert property (
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (state_reg == GDPC_ST_IDLE && !arm_in) |=> !armed_out)
        else $error("Disarmed counter reacted to gate");

    edge_count_a: assert property (
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (counter_mode_config_in == GDPC_MODE_EDGE && counting && src_rise
         && !gdpc_at_one(count_reg) && !disarm_in && !load_cmd_in)
        |=> count_reg == $past(count_reg) - GDPC_DECR)
        else $error("Edge mode missed a source edge");

    term_value_a: assert property (
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        terminal_count_event_out |-> $past(count_reg) == GDPC_ONE)
        else $error("Terminal count not after value one");

    // Pulse may only start together with the first terminal count
    pulse_span_a: assert property (
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        $rose(pulse_out)
        |-> terminal_count_event_out && state_reg == GDPC_ST_PULSE)
        else $error("Pulse began outside first terminal count");

endmodule : gdpc_counter

`default_nettype wire

// File: verif/gdpc_far_side.sv
// Far-side model: count source, gate driver and host commands
`default_nettype none

module gdpc_far_side
(
    input  wire logic sys_clk_in,   // System clock
    output logic      source_out,   // Count source level
    output logic      gate_out,     // Gate level
    output logic      arm_out,      // Arm command pulse
    output logic      disarm_out,   // Disarm command pulse
    output logic      load_cmd_out  // Load command pulse
);
    timeunit 1ns;
    timeprecision 1ns;

    // =========================================================
    // Idle levels at time zero
    // =========================================================
    initial
    begin
        source_out   = 1'h0;
        gate_out     = 1'h0;
        arm_out      = 1'h0;
        disarm_out   = 1'h0;
        load_cmd_out = 1'h0;
    end

    // One source edge: high one cycle, then low
    task automatic src_edge();
        @(posedge sys_clk_in) source_out <= 1'h1;
        @(posedge sys_clk_in) source_out <= 1'h0;
        @(posedge sys_clk_in);
    endtask : src_edge

    // New gate level, held at least one cycle
    task automatic set_gate(input logic v);
        @(posedge sys_clk_in) gate_out <= v;
        @(posedge sys_clk_in);
    endtask : set_gate

    // Arm pulse; the gate edge must come after it
    task automatic arm();
        @(posedge sys_clk_in) arm_out <= 1'h1;
        @(posedge sys_clk_in) arm_out <= 1'h0;
    endtask : arm

    // Disarm pulse, stops any count sequence
    task automatic disarm();
        @(posedge sys_clk_in) disarm_out <= 1'h1;
        @(posedge sys_clk_in) disarm_out <= 1'h0;
    endtask : disarm

    // Load pulse, only given while disarmed
    task automatic load();
        @(posedge sys_clk_in) load_cmd_out <= 1'h1;
        @(posedge sys_clk_in) load_cmd_out <= 1'h0;
    endtask : load
endmodule : gdpc_far_side

`default_nettype wire

// File: verif/gdpc_counter_tb.sv
// Testbench for the gated delayed-pulse counter
`default_nettype none

module gdpc_counter_tb
    import gdpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // =========================================================
    // Signals
    // =========================================================
    logic                  clk;         // 25 MHz clock
    logic                  rst;         // Reset, high
    logic                  source;      // From far side
    logic                  gate;        // From far side
    logic                  arm;         // From far side
    logic                  disarm;      // From far side
    logic                  load_cmd;    // From far side
    gdpc_mode_type         mode;        // Mode select
    logic [GDPC_WIDTH-1:0] load_val;    // Load value
    logic [GDPC_WIDTH-1:0] hold_val;    // Hold value
    logic [GDPC_WIDTH-1:0] count;       // Counter contents
    logic                  armed;       // Armed flag
    logic                  term_evt;    // Terminal count pulse
    logic                  pulse;       // Delayed pulse
    int                    error_cnt;   // Mismatches
    int                    cmp_count;   // Comparisons
    int                    term_cnt;    // Terminal counts seen
    int                    cyc;         // Cycles for timeout

    gdpc_far_side far (.sys_clk_in(clk), .source_out(source),
        .gate_out(gate), .arm_out(arm), .disarm_out(disarm),
        .load_cmd_out(load_cmd));

    gdpc_counter uut (.sys_clk_in(clk), .sys_rst_in(rst),
        .source_in(source), .gate_in(gate), .arm_in(arm),
        .disarm_in(disarm), .load_cmd_in(load_cmd),
        .counter_mode_config_in(mode), .load_value_in(load_val),
        .hold_value_in(hold_val), .count_out(count),
        .armed_out(armed), .terminal_count_event_out(term_evt),
        .pulse_out(pulse));

    // Clock, and tally of one-cycle terminal pulses
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        if (term_evt === 1'h1)
            term_cnt++;
        cyc++;
        if (cyc == 4000)
        begin
            error_cnt++;
            close_out();
        end
    end

    // =========================================================
    // Helpers
    // =========================================================
    task automatic chk_val(input logic [15:0] g, e, input string m);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk_val

    task automatic chk_bit(input logic g, e, input string m);
        chk_val({15'h0, g}, {15'h0, e}, m);
    endtask : chk_bit

    // Let outputs settle past the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // Send n source edges, then wait for the count
    task automatic edges(input int n);
        repeat (n) far.src_edge();
        settle(2);
    endtask : edges

    // =========================================================
    // Level-gated mode
    // =========================================================
    task automatic t_level();
        mode     <= GDPC_MODE_LEVEL;
        load_val <= 16'h0003;
        hold_val <= 16'h0002;
        far.set_gate(1'h1);
        far.load();
        settle(1);
        chk_val(count, 16'h0003, "load");
        edges(2);
        chk_val(count, 16'h0003, "count disarmed");
        far.arm();
        far.set_gate(1'h0);
        edges(2);
        chk_bit(armed, 1'h1, "armed");
        chk_val(count, 16'h0003, "count gate low");
        far.set_gate(1'h1);
        edges(2);
        chk_val(count, 16'h0001, "count gate high");
        chk_val(16'(term_cnt), 16'h0000, "early terminal");
        edges(1);
        chk_val(count, 16'h0002, "hold reload");
        chk_val(16'(term_cnt), 16'h0001, "first terminal");
        chk_bit(pulse, 1'h1, "pulse on");
        far.set_gate(1'h0);
        edges(2);
        chk_val(count, 16'h0002, "pulse paused");
        far.set_gate(1'h1);
        edges(2);
        chk_val(count, 16'h0003, "load reload");
        chk_bit(armed, 1'h0, "disarm");
        chk_bit(pulse, 1'h0, "pulse off");
        chk_val(16'(term_cnt), 16'h0002, "second terminal");
        $display("t_level done");
    endtask : t_level

    // =========================================================
    // Edge-triggered mode
    // =========================================================
    task automatic t_edge();
        @(posedge clk);
        mode     <= GDPC_MODE_EDGE;
        load_val <= 16'h0002;
        hold_val <= 16'h0001;
        far.set_gate(1'h0);
        far.load();
        far.set_gate(1'h1);
        edges(1);
        chk_val(count, 16'h0002, "gate disarmed");
        far.set_gate(1'h0);
        far.arm();
        edges(1);
        chk_val(count, 16'h0002, "no trigger");
        far.set_gate(1'h1);
        edges(1);
        chk_val(count, 16'h0001, "first count");
        far.set_gate(1'h0);
        edges(1);
        chk_val(count, 16'h0001, "hold reload");
        chk_bit(pulse, 1'h1, "pulse on");
        far.set_gate(1'h1);
        edges(1);
        chk_val(count, 16'h0002, "load reload");
        chk_bit(armed, 1'h0, "self disarm");
        far.set_gate(1'h0);
        far.set_gate(1'h1);
        edges(1);
        chk_val(count, 16'h0002, "no restart");
        $display("t_edge done");
    endtask : t_edge

    // =========================================================
    // Disarm command, wide values and reset in mid-run
    // =========================================================
    task automatic t_disarm();
        @(posedge clk);
        mode     <= GDPC_MODE_LEVEL;
        load_val <= 16'h0001;
        hold_val <= 16'hfffe;
        far.load();
        far.arm();
        edges(1);
        chk_val(count, 16'hfffe, "wide hold reload");
        chk_bit(pulse, 1'h1, "wide pulse on");
        chk_val(16'(term_cnt), 16'h0005, "terminal tally");
        far.disarm();
        settle(1);
        chk_bit(armed, 1'h0, "disarm command");
        chk_bit(pulse, 1'h0, "pulse cut");
        edges(1);
        chk_val(count, 16'hfffe, "count after disarm");
        @(posedge clk);
        load_val <= 16'hffff;
        far.load();
        settle(1);
        chk_val(count, 16'hffff, "wide load");
        @(posedge clk);
        rst <= 1'h1;
        settle(1);
        chk_val(count, 16'h0000, "reset count");
        chk_bit(armed, 1'h0, "reset disarm");
        chk_bit(pulse, 1'h0, "reset pulse");
        @(posedge clk);
        rst <= 1'h0;
        far.load();
        settle(1);
        chk_val(count, 16'hffff, "load after reset");
        $display("t_disarm done");
    endtask : t_disarm

    // Verdict and end of run
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    // Main sequence
    initial
    begin
        clk       = 1'h0;
        rst       = 1'h1;
        mode      = GDPC_MODE_LEVEL;
        load_val  = 16'h0000;
        hold_val  = 16'h0000;
        error_cnt = 0;
        cmp_count = 0;
        term_cnt  = 0;
        cyc       = 0;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        t_level();
        t_edge();
        t_disarm();
        close_out();
    end
endmodule : gdpc_counter_tb

`default_nettype wire
